// ===== verilog/see_consts.svh
// constants for the serial eeprom front end: opcodes, field widths, timing
// assumes inclusion by bare name from the design files
`ifndef SEE_CONSTS_SVH
`define SEE_CONSTS_SVH
// control register bit positions
`define SEE_BIT_SEL      4
`define SEE_BIT_SCLK     5
`define SEE_BIT_SIN      6
`define SEE_BIT_SOUT     7
// two-bit opcodes after the start bit
`define SEE_OP_EXT       2'h0
`define SEE_OP_WRITE     2'h1
`define SEE_OP_READ      2'h2
`define SEE_OP_ERASE     2'h3
// sub-codes of the extended opcode
`define SEE_SUB_DIS      2'h0
`define SEE_SUB_WRALL    2'h1
`define SEE_SUB_ERALL    2'h2
`define SEE_SUB_EN       2'h3
// field lengths
`define SEE_ADDR_BITS    7
`define SEE_DATA_BITS    8
// internal write cycle time in microseconds
`define SEE_WRITE_US     2000
`define SEE_CLK_MHZ      250
`define SEE_CR_RESET     8'h00
`endif

// ===== verilog/see_pkg.sv
// types shared by the serial eeprom front end
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package see_pkg;
  // serial front end states
  typedef enum logic [2:0] {
    SEE_IDLE, SEE_SHIFT, SEE_READ, SEE_WAIT, SEE_BUSY
  } see_state_e;
endpackage
`default_nettype wire

// ===== verilog/see_mem.sv
// small array memory with registered read data
// assumes a single clock; writes win nothing over reads, read-before-write
`timescale 1ns/1ps
`default_nettype none
module see_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock
  input  wire logic          core_clk,
  // write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // read port
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1]; // storage cells, no reset like real cells

  // one write a cycle, read data registered
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // see_mem
`default_nettype wire

// ===== verilog/see_eeprom.sv
// serial front end of a 128-byte data eeprom behind a bit-bang register
// assumes software drives select, shift clock and serial input by writing
// the control register; the internal cycle runs on core_clk
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "see_consts.svh"

// Summary of operation
// - erase-all leaves every bit at one
// - erase-all acts only on select falling
// - write-all stores byte to every location
// - write-all needs no prior erase
// - byte erase sets addressed byte to ones
// - select fall after complete instruction starts cycle
// - cycle timed internally, no shift clock
// - instructions ignored while cycle runs
// - select high during cycle: output low
// - cycle end drives output high
// - write and erase refused while disabled
// - address seven bits, data eight, msb first
// - bits 4..7 select, clock, in, out
// - serial input sampled on shift clock rise
// - enable holds until disable instruction
module see_eeprom #(
  parameter int AW        = `SEE_ADDR_BITS,
  parameter int DW        = `SEE_DATA_BITS,
  parameter int CYCLE_CNT = `SEE_WRITE_US * `SEE_CLK_MHZ
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // register port
  input  wire logic [7:0]   regAddr,
  input  wire logic [7:0]   regWrData,
  input  wire logic         regWr,
  input  wire logic         regRd,
  output logic      [7:0]   regRdData,
  // status
  output logic              writeBusy,
  output logic              writeEnabled
);
  localparam int LEN   = 3 + AW + DW; // start, opcode, address, data
  localparam int CW    = $clog2(CYCLE_CNT + 1);
  localparam int WORDS = 1 << AW;

  // refuse geometries the decoder cannot serve
  initial begin
    if (AW != 7 || DW != 8 || CYCLE_CNT < 2) begin
      $error("see_eeprom: unsupported parameters");
    end
  end

  // control register bits written by software
  logic         ctlSel;        // select line
  logic         ctlClk;        // shift clock line
  logic         ctlIn;         // serial input line
  logic         serialOut;     // serial output bit
  logic         prevClk;       // shift clock history for edge find
  logic         prevSel;       // select history for edge find
  logic [LEN-1:0] shiftReg;    // received bits, lsb newest
  logic [4:0]   bitCnt;        // bits received in this frame
  logic [CW-1:0] cycleCnt;     // remaining internal cycle time
  logic [AW-1:0] memWrAddr;    // array write address
  logic [DW-1:0] memWrData;    // array write data
  logic         memWrEn;       // array write strobe
  logic [AW-1:0] sweepAddr;    // address walk for whole-array ops
  logic         sweepAll;      // whole-array operation in progress
  logic [AW-1:0] rdAddrCur;    // read pointer
  logic [DW-1:0] memRd;        // registered read data
  logic [DW-1:0] outShift;     // byte being shifted out
  logic [3:0]   outCnt;        // bits left in outgoing byte
  logic [DW-1:0] opData;       // data for pending write
  logic [AW-1:0] opAddr;       // address for pending write
  see_pkg::see_state_e state;  // front end state

  // decoded edges of the software-driven lines
  logic clkRise;
  logic selFall;
  logic selRise;
  assign clkRise = ctlClk & ~prevClk;
  assign selFall = prevSel & ~ctlSel;
  assign selRise = ctlSel & ~prevSel;

  // frame fields from the shift register
  function automatic logic [1:0] opOf(input logic [LEN-1:0] s,
                                      input logic [4:0] n);
    logic [LEN-1:0] t;
    t = s >> (n - 5'd3);
    opOf = t[1:0];
  endfunction

  // register writes; only the control address responds
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctlSel <= 1'b0;
      ctlClk <= 1'b0;
      ctlIn  <= 1'b0;
    end else if (regWr && regAddr == 8'h00) begin
      ctlSel <= regWrData[`SEE_BIT_SEL];
      ctlClk <= regWrData[`SEE_BIT_SCLK];
      ctlIn  <= regWrData[`SEE_BIT_SIN];
    end
  end

  // read data one cycle later; low nibble zero, unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= `SEE_CR_RESET;
    end else if (regRd && regAddr == 8'h00) begin
      regRdData <= {serialOut, ctlIn, ctlClk, ctlSel, 4'h0};
    end else begin
      regRdData <= 8'h00;
    end
  end

  // line history for edge detection; lines are same-domain registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prevClk <= 1'b0;
      prevSel <= 1'b0;
    end else begin
      prevClk <= ctlClk;
      prevSel <= ctlSel;
    end
  end

  // main sequencer: shifting, decoding, the internal cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= see_pkg::SEE_IDLE;
      shiftReg     <= '0;
      bitCnt       <= 5'd0;
      cycleCnt     <= '0;
      writeEnabled <= 1'b0;
      sweepAll     <= 1'b0;
      sweepAddr    <= '0;
      opData       <= '0;
      opAddr       <= '0;
      rdAddrCur    <= '0;
    end else begin
      unique case (state)
        see_pkg::SEE_IDLE: begin
          bitCnt <= 5'd0;
          if (ctlSel && clkRise && ctlIn) begin
            // start bit seen; begin collecting the frame
            shiftReg <= {{(LEN-1){1'b0}}, 1'b1};
            bitCnt   <= 5'd1;
            state    <= see_pkg::SEE_SHIFT;
          end
        end
        see_pkg::SEE_SHIFT: begin
          if (clkRise && ctlSel && bitCnt < 5'(LEN)) begin
            shiftReg <= {shiftReg[LEN-2:0], ctlIn};
            bitCnt   <= bitCnt + 5'd1;
            // a read switches to data out once the address is in
            if (bitCnt == 5'(2 + AW) &&
                shiftReg[AW:AW-1] == `SEE_OP_READ) begin
              rdAddrCur <= {shiftReg[AW-2:0], ctlIn};
              state     <= see_pkg::SEE_READ;
            end
          end else if (selFall) begin
            state <= see_pkg::SEE_IDLE;
            // only a complete instruction acts on select falling
            if (bitCnt == 5'(3 + AW)) begin
              unique case (opOf(shiftReg, bitCnt))
                `SEE_OP_ERASE: begin
                  if (writeEnabled) begin
                    opAddr   <= shiftReg[AW-1:0];
                    opData   <= '1;
                    sweepAll <= 1'b0;
                    cycleCnt <= CW'(CYCLE_CNT);
                    state    <= see_pkg::SEE_BUSY;
                  end
                end
                `SEE_OP_EXT: begin
                  unique case (shiftReg[AW-1:AW-2])
                    `SEE_SUB_EN:  writeEnabled <= 1'b1;
                    `SEE_SUB_DIS: writeEnabled <= 1'b0;
                    `SEE_SUB_ERALL: begin
                      if (writeEnabled) begin
                        opData    <= '1;
                        sweepAll  <= 1'b1;
                        sweepAddr <= '0;
                        cycleCnt  <= CW'(CYCLE_CNT);
                        state     <= see_pkg::SEE_BUSY;
                      end
                    end
                    default: ;
                  endcase
                end
                default: ;
              endcase
            end else if (bitCnt == 5'(LEN) && writeEnabled) begin
              // data-carrying writes; new data overwrites, no erase needed
              opData   <= shiftReg[DW-1:0];
              opAddr   <= shiftReg[DW+AW-1:DW];
              cycleCnt <= CW'(CYCLE_CNT);
              sweepAddr <= '0;
              if (shiftReg[LEN-2:LEN-3] == `SEE_OP_WRITE) begin
                sweepAll <= 1'b0;
                state    <= see_pkg::SEE_BUSY;
              end else if (shiftReg[LEN-2:LEN-3] == `SEE_OP_EXT &&
                  shiftReg[DW+AW-1:DW+AW-2] == `SEE_SUB_WRALL) begin
                sweepAll <= 1'b1;
                state    <= see_pkg::SEE_BUSY;
              end
            end
          end
        end
        see_pkg::SEE_READ: begin
          // sequential read runs until select drops
          if (selFall) begin
            state <= see_pkg::SEE_IDLE;
          end else if (clkRise && outCnt <= 4'd1) begin
            // advance as the byte is loaded, so the registered read data
            // already hold the next byte when the following load comes
            rdAddrCur <= rdAddrCur + AW'(1);
          end
        end
        see_pkg::SEE_BUSY: begin
          // self-timed on core_clk; serial lines are ignored here
          if (sweepAll && sweepAddr != AW'(WORDS - 1)) begin
            sweepAddr <= sweepAddr + AW'(1);
          end
          if (cycleCnt > CW'(1)) begin
            cycleCnt <= cycleCnt - CW'(1);
          end else begin
            cycleCnt <= '0;
            state    <= see_pkg::SEE_WAIT;
          end
        end
        see_pkg::SEE_WAIT: begin
          // wait for select low so a new frame starts clean
          if (!ctlSel) begin
            state <= see_pkg::SEE_IDLE;
          end
        end
      endcase
    end
  end

  // array write: one word, or one word a cycle while sweeping
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      memWrEn   <= 1'b0;
      memWrAddr <= '0;
      memWrData <= '0;
    end else begin
      memWrEn   <= (state == see_pkg::SEE_BUSY) &&
                   (sweepAll || cycleCnt == CW'(CYCLE_CNT));
      memWrAddr <= sweepAll ? sweepAddr : opAddr;
      memWrData <= opData;
    end
  end

  // read data shifter: dummy zero then msb first, back to back bytes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      outShift <= '0;
      outCnt   <= 4'd0;
    end else if (state != see_pkg::SEE_READ) begin
      outCnt <= 4'd0;
    end else if (clkRise) begin
      if (outCnt <= 4'd1) begin
        outShift <= memRd;
        outCnt   <= 4'(DW);
      end else begin
        outShift <= {outShift[DW-2:0], 1'b0};
        outCnt   <= outCnt - 4'd1;
      end
    end
  end

  // serial output: busy low while selected in cycle, ready high after
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serialOut <= 1'b1;
    end else if (state == see_pkg::SEE_BUSY) begin
      serialOut <= ctlSel ? 1'b0 : serialOut;
    end else if (state == see_pkg::SEE_READ) begin
      serialOut <= (outCnt == 4'd0) ? 1'b0 : outShift[DW-1];
    end else begin
      serialOut <= 1'b1;
    end
  end

  assign writeBusy = (state == see_pkg::SEE_BUSY);

  // array storage
  see_mem #(
    .AW (AW),
    .DW (DW)
  ) u_mem (
    .core_clk (core_clk),
    .wrEn     (memWrEn),
    .wrAddr   (memWrAddr),
    .wrData   (memWrData),
    .rdAddr   (rdAddrCur),
    .rdData   (memRd)
  );

  logic unusedSelRise;
  assign unusedSelRise = selRise;
endmodule // see_eeprom
`default_nettype wire

// ===== bench/see_eeprom_sva.sv
// checker for the serial eeprom front end, bound to its top module
// assumes one clock domain and the control register at offset 0x00
`timescale 1ns/1ps
`default_nettype none
module see_eeprom_chk #(
  parameter int CYCLE_CNT = 300
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regRdData,
  // status
  input  wire logic       writeBusy,
  input  wire logic       writeEnabled
);
  logic [2:0]  lastLines; // lines as software last wrote them
  int unsigned busyLen;   // length of the running internal cycle
  // shadow of the written lines
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastLines <= 3'h0;
    end else if (regWr && regAddr == 8'h00) begin
      lastLines <= regWrData[6:4];
    end
  end
  // cycle counter, cleared whenever the cycle is idle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyLen <= 0;
    end else begin
      busyLen <= writeBusy ? busyLen + 1 : 0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence readCtrl;
    regRd && regAddr == 8'h00;
  endsequence
  rd_idle_a: assert property (!$past(regRd && regAddr == 8'h00) |-> regRdData == 8'h00)
    else $error("read data outside a read slot");
  low_nibble_a: assert property (regRdData[3:0] == 4'h0)
    else $error("low nibble not zero");
  rd_echo_a: assert property (readCtrl |=> regRdData[6:4] == $past(lastLines))
    else $error("line echo wrong");
  busy_out_a: assert property (readCtrl ##0 (writeBusy && $past(writeBusy) && lastLines[0]) |=> !regRdData[7])
    else $error("output not low while busy");
  busy_start_a: assert property ($rose(writeBusy) |-> $past(regWr, 2) && !$past(regWrData[4], 2))
    else $error("cycle began without select fall");
  busy_len_a: assert property ($fell(writeBusy) |-> busyLen >= CYCLE_CNT - 1 && busyLen <= CYCLE_CNT + 1)
    else $error("internal cycle length wrong");
  busy_max_a: assert property (writeBusy |-> busyLen <= CYCLE_CNT + 1)
    else $error("internal cycle overran");
  en_stable_a: assert property (writeBusy && $past(writeBusy) |-> $stable(writeEnabled))
    else $error("enable changed while busy");
  en_change_a: assert property ($changed(writeEnabled) |-> $past(regWr) || $past(regWr, 2) || $past(regWr, 3))
    else $error("enable changed with no instruction");
endmodule // see_eeprom_chk
bind see_eeprom see_eeprom_chk #(.CYCLE_CNT(CYCLE_CNT)) i_see_eeprom_chk (
  .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .writeBusy(writeBusy),
  .writeEnabled(writeEnabled));
`default_nettype wire

// ===== bench/see_host.sv
// host model: bit-bangs select, shift clock and serial input by register
// assumes a 4 ns core clock; shift clock runs 56 ns only inside frames
`timescale 1ns/1ps
`default_nettype none
module see_host (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdData
);
  localparam int HALF = 6; // half shift clock in core cycles, less one
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // one write, lines then held half a shift clock
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= 8'h00;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    repeat (HALF - 1) @(posedge core_clk);
  endtask
  // one read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 q = regRdData;
  endtask
  // select first, then bits msb first, data set before each rise
  task automatic frame(input logic [31:0] v, input int n, input bit hold);
    wr(8'h10);
    for (int i = n - 1; i >= 0; i--) begin
      wr({1'b0, v[i], 2'b01, 4'h0});
      wr({1'b0, v[i], 2'b11, 4'h0});
    end
    if (!hold) begin
      wr(8'h00);
    end
  endtask
  // select high, poll output without any shift clock, count busy reads
  task automatic poll(output int n);
    logic [7:0] q;
    n = 0;
    wr(8'h10);
    do begin
      rd(8'h00, q);
      n += !q[7];
    end while (!q[7] && n < 400);
    wr(8'h00);
  endtask
  // read frame: dummy bit after the address, then eight data bits
  task automatic rdbyte(input logic [6:0] a, output logic dum,
                        output logic [7:0] d);
    logic [7:0] q;
    frame({3'b110, a}, 10, 1'b1);
    rd(8'h00, q);
    dum = q[7];
    for (int i = 7; i >= 0; i--) begin
      wr(8'h10);
      wr(8'h30);
      rd(8'h00, q);
      d[i] = q[7];
    end
    wr(8'h00);
  endtask
endmodule // see_host
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench: host model drives the eeprom front end
// assumes a shortened internal cycle of 300 core cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk = 1'b0; // 250 MHz core clock
  logic        rst_b    = 1'b0; // reset, active low
  logic [7:0]  regAddr, regWrData, regRdData, q;
  logic        regWr, regRd, writeBusy, writeEnabled, dum;
  logic [31:0] seed = 32'h47ab; // xorshift state
  logic [31:0] a, d;            // random address and data
  int          miscompares, total_checks, n;
  int          mdl[128];        // expected array contents
  always #2 core_clk = ~core_clk;
  see_eeprom #(.CYCLE_CNT(300)) i_see_eeprom (
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .writeBusy(writeBusy),
    .writeEnabled(writeEnabled));
  see_host i_see_host (
    .core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // busy seen low at once, ready once the cycle has run out; the window
  // shrinks when part of the cycle was spent on an ignored frame
  task automatic pollchk(input int lo, input int hi);
    i_see_host.poll(n);
    chk("busyPolls", 8'h01, {7'h0, n >= lo && n <= hi});
  endtask
  task automatic rdchk(input logic [6:0] ad);
    i_see_host.rdbyte(ad, dum, q);
    chk("dummy", 8'h00, {7'h0, dum});
    chk("mem", 8'(mdl[ad]), q);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    i_see_host.rd(8'h00, q);
    chk("ctrl", 8'h80, q);
    i_see_host.rd(8'h5a, q);
    chk("unmapped", 8'h00, q);
    d = xs();
    i_see_host.frame({5'b10010, d[4:0]}, 10, 1'b0); // refused erase-all
    repeat (4) @(posedge core_clk);
    chk("busyOff", 8'h00, {7'h0, writeBusy});
    i_see_host.frame({5'b10011, d[4:0]}, 10, 1'b0);
    chk("enabled", 8'h01, {7'h0, writeEnabled});
    a = xs();
    d = xs();
    i_see_host.frame({3'b101, a[6:0], d[7:0]}, 18, 1'b0);
    mdl[a[6:0]] = d[7:0];
    pollchk(130, 160);
    rdchk(a[6:0]);
    i_see_host.frame({5'b10010, d[4:0]}, 10, 1'b0); // erase-all
    i_see_host.frame({5'b10000, d[4:0]}, 10, 1'b0); // disable while busy
    chk("enBusy", 8'h01, {7'h0, writeEnabled});
    pollchk(55, 80);
    foreach (mdl[i]) mdl[i] = 255;
    rdchk(7'h7f);
    rdchk(a[6:0] ^ 7'h2a);
    d = xs();
    i_see_host.frame({10'h220 | d[12:8], d[7:0]}, 18, 1'b0); // write-all
    pollchk(130, 160);
    foreach (mdl[i]) mdl[i] = d[7:0];
    rdchk(7'h00);
    rdchk(a[6:0]);
    i_see_host.frame({3'b111, a[6:0]}, 10, 1'b0); // byte erase
    pollchk(130, 160);
    mdl[a[6:0]] = 255;
    rdchk(a[6:0]);
    rdchk(a[6:0] ^ 7'h01);
    i_see_host.frame({5'b10000, d[4:0]}, 10, 1'b0); // disable
    chk("disabled", 8'h00, {7'h0, writeEnabled});
    i_see_host.frame({10'h220, ~d[7:0]}, 18, 1'b0); // refused write-all
    repeat (4) @(posedge core_clk);
    chk("busyOff", 8'h00, {7'h0, writeBusy});
    rdchk(a[6:0] ^ 7'h01);
    complete_run();
  end
  // watchdog well beyond the expected run of about 20 us
  initial begin
    #300000;
    miscompares++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
